//--- shared/sct_pkg.sv
// Constants and types for the subtract-with-carry trapping datapath
`default_nettype none
package sct_pkg;
	localparam int          SCT_DATA_W        = 32;
	localparam int          SCT_REG_IDX_W     = 8;
	localparam int          SCT_REG_COUNT     = 256;

	// Instruction field positions
	localparam int          SCT_OPC_MSB       = 31;
	localparam int          SCT_OPC_LSB       = 24;
	localparam int          SCT_TGT_MSB       = 23;
	localparam int          SCT_TGT_LSB       = 16;
	localparam int          SCT_FSRC_MSB      = 15;
	localparam int          SCT_FSRC_LSB      = 8;
	localparam int          SCT_SSRC_MSB      = 7;
	localparam int          SCT_SSRC_LSB      = 0;
	localparam int          SCT_IMM_SEL_BIT   = 0;

	// Opcode pairs with the select bit cleared
	localparam logic [7:0]  SCT_OPC_SUB_WITH_CARRY      = 8'h2C;
	localparam logic [7:0]  SCT_OPC_SUB_WITH_CARRY_S    = 8'h28;
	localparam logic [7:0]  SCT_OPC_SUB_WITH_CARRY_U    = 8'h2A;
	localparam logic [7:0]  SCT_OPC_RSUB      = 8'h34;

	// Reset values
	localparam logic [31:0] SCT_RST_WORD      = 32'h0000_0000;
	localparam logic [7:0]  SCT_RST_IDX       = 8'h00;
	localparam logic        SCT_RST_BIT       = 1'b0;

	typedef struct packed {
		logic v;
		logic n;
		logic z;
		logic c;
	} sct_flags_t;

	localparam sct_flags_t  SCT_RST_FLAGS     = '{v: 1'b0, n: 1'b0, z: 1'b0, c: 1'b0};

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] target_field;
		logic [7:0] first_source_field;
		logic [7:0] second_source_field;
	} sct_instr_t;

	typedef enum logic [1:0] {
		SCT_OP_SUB_WITH_CARRY              = 2'b00,
		SCT_OP_SUB_WITH_CARRY_SIGNED_TRAP  = 2'b01,
		SCT_OP_SUB_WITH_CARRY_UNSIGNED_TRAP = 2'b11,
		SCT_OP_REVERSE_SUB                 = 2'b10
	} sct_op_t;

	typedef struct packed {
		logic [7:0]  result_target;
		logic [31:0] value;
	} sct_wb_t;
endpackage
`default_nettype wire

//--- src/sct_alu.sv
// Subtract-with-carry, trapping variants and reverse subtract with its register file
`timescale 1ns/10ps
`default_nettype none
module sct_alu
	import sct_pkg::*;
#(
	parameter int DATA_W    = SCT_DATA_W,
	parameter int REG_COUNT = SCT_REG_COUNT
) (
	// Clock and reset
	input  wire logic               i_clk_sys,
	input  wire logic               i_rst_n,
	// Instruction issue
	input  wire logic               i_instr_valid,
	input  wire sct_instr_t         i_instr,
	// Side register-file load port
	input  wire logic               i_reg_wr_en,
	input  wire logic [7:0]         i_reg_wr_idx,
	input  wire logic [DATA_W-1:0]  i_reg_wr_data,
	// Register-file observation port
	input  wire logic [7:0]         i_reg_rd_idx,
	output logic      [DATA_W-1:0]  o_reg_rd_data,
	// Status flag load
	input  wire logic               i_flags_wr_en,
	input  wire sct_flags_t         i_flags_wr,
	// Completion
	output logic                    o_done,
	output logic                    o_unsupported,
	output sct_wb_t                 o_wb,
	output sct_flags_t              o_flags,
	// Exception logic
	output logic                    o_trap_out_of_range
);
	logic [DATA_W-1:0] reg_file_r [REG_COUNT];
	sct_flags_t        flags_r;
	sct_flags_t        flags_nxt;

	// Decode results
	logic              imm_sel;
	logic              op_hit;
	sct_op_t           op_kind;
	// Datapath
	logic [DATA_W-1:0] first_source;
	logic [DATA_W-1:0] second_source;
	logic [DATA_W-1:0] add_left;
	logic [DATA_W-1:0] add_right;
	logic              add_cin;
	logic [DATA_W:0]   add_sum;
	logic [DATA_W-1:0] result;
	logic              signed_ovf;
	logic              unsigned_unf;
	logic              trap_nxt;
	logic              do_exec;
	// Per-entry write strobes
	logic [REG_COUNT-1:0] ins_hit;
	logic [REG_COUNT-1:0] side_hit;

	// Decode; the select bit is ignored when matching the pair
	always_comb begin
		imm_sel = i_instr.opcode[SCT_IMM_SEL_BIT];
		op_hit  = 1'b1;
		op_kind = SCT_OP_SUB_WITH_CARRY;
		case ({i_instr.opcode[7:1], 1'b0})
			SCT_OPC_SUB_WITH_CARRY: begin
				op_kind = SCT_OP_SUB_WITH_CARRY;
			end
			SCT_OPC_SUB_WITH_CARRY_S: begin
				op_kind = SCT_OP_SUB_WITH_CARRY_SIGNED_TRAP;
			end
			SCT_OPC_SUB_WITH_CARRY_U: begin
				op_kind = SCT_OP_SUB_WITH_CARRY_UNSIGNED_TRAP;
			end
			SCT_OPC_RSUB: begin
				op_kind = SCT_OP_REVERSE_SUB;
			end
			default: begin
				op_hit = 1'b0;
			end
		endcase
	end

	// Refused opcodes leave every register, flag and view untouched
	assign do_exec = i_instr_valid && op_hit;

	// Operand fetch straight from the array, so back-to-back issue needs no forwarding
	always_comb begin
		first_source = reg_file_r[i_instr.first_source_field];
		if (imm_sel) begin
			second_source = {{(DATA_W-8){1'b0}}, i_instr.second_source_field};
		end else begin
			second_source = reg_file_r[i_instr.second_source_field];
		end
	end

	// One adder serves every form; only the inversion and carry-in differ
	always_comb begin
		// Reverse form takes a fixed carry-in and ignores the carry flag
		if (op_kind == SCT_OP_REVERSE_SUB) begin
			add_left  = second_source;
			add_right = ~first_source;
			add_cin   = 1'b1;
		end else begin
			add_left  = first_source;
			add_right = ~second_source;
			add_cin   = flags_r.c;
		end
		add_sum = {1'b0, add_left} + {1'b0, add_right} + {{DATA_W{1'b0}}, add_cin};
		result  = add_sum[DATA_W-1:0];
	end

	// Overflow judged on the addends actually summed
	always_comb begin
		signed_ovf   = (add_left[DATA_W-1] == add_right[DATA_W-1])
			&& (result[DATA_W-1] != add_left[DATA_W-1]);
		// Underflow is the missing carry out of the sum
		unsigned_unf = ~add_sum[DATA_W];
		case (op_kind)
			SCT_OP_SUB_WITH_CARRY_SIGNED_TRAP: begin
				trap_nxt = signed_ovf;
			end
			SCT_OP_SUB_WITH_CARRY_UNSIGNED_TRAP: begin
				trap_nxt = unsigned_unf;
			end
			default: begin
				trap_nxt = 1'b0;
			end
		endcase
	end

	always_comb begin
		flags_nxt   = flags_r;
		if (do_exec) begin
			flags_nxt.v = signed_ovf;
			flags_nxt.n = result[DATA_W-1];
			flags_nxt.z = (result == '0);
			flags_nxt.c = add_sum[DATA_W];
		end else if (i_flags_wr_en) begin
			flags_nxt = i_flags_wr;
		end
	end

	// Status flags; an executing instruction wins over a side load
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			flags_r <= SCT_RST_FLAGS;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// Per-entry strobes; a clash on one index keeps the instruction's result
	for (genvar gi = 0; gi < REG_COUNT; gi++) begin : g_reg_entry
		assign ins_hit[gi]  = do_exec && (i_instr.target_field == SCT_REG_IDX_W'(gi));
		assign side_hit[gi] = i_reg_wr_en && (i_reg_wr_idx == SCT_REG_IDX_W'(gi));
	end

	// No reset on the array: load an entry before any instruction reads it
	always_ff @(posedge i_clk_sys) begin
		for (int e = 0; e < REG_COUNT; e++) begin
			if (ins_hit[e]) begin
				// Target written even when trapping
				reg_file_r[e] <= result;
			end else if (side_hit[e]) begin
				reg_file_r[e] <= i_reg_wr_data;
			end
		end
	end

	// Completion pulse
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_done <= SCT_RST_BIT;
		end else begin
			o_done <= do_exec;
		end
	end

	// Refusal pulse for any opcode outside the group
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_unsupported <= SCT_RST_BIT;
		end else begin
			o_unsupported <= i_instr_valid && !op_hit;
		end
	end

	// Trap request, aligned with the completion pulse
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_trap_out_of_range <= SCT_RST_BIT;
		end else begin
			o_trap_out_of_range <= do_exec && trap_nxt;
		end
	end

	// Write-back view holds until the next executed instruction
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_wb.result_target <= SCT_RST_IDX;
			o_wb.value         <= SCT_RST_WORD;
		end else if (do_exec) begin
			o_wb.result_target <= i_instr.target_field;
			o_wb.value         <= result;
		end
	end

	// Flag view mirrors the flag register after every edge
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_flags <= SCT_RST_FLAGS;
		end else begin
			o_flags <= flags_nxt;
		end
	end

	// Read port shows the array as it stood before any write of the same edge; that write appears one edge later
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_reg_rd_data <= SCT_RST_WORD;
		end else begin
			o_reg_rd_data <= reg_file_r[i_reg_rd_idx];
		end
	end
endmodule
`default_nettype wire

//--- verif/sct_alu_sva.sv
// Port-level checks of the subtract datapath
`timescale 1ns/10ps
`default_nettype none
module sct_alu_sva
	import sct_pkg::*;
(
	input wire logic       i_clk_sys,
	input wire logic       i_rst_n,
	input wire logic       i_instr_valid,
	input wire sct_instr_t i_instr,
	input wire logic       o_done,
	input wire logic       o_unsupported,
	input wire sct_wb_t    o_wb,
	input wire sct_flags_t o_flags,
	input wire logic       o_trap_out_of_range
);
	logic [6:0] pr;
	logic       ok;
	assign pr = i_instr.opcode[7:1];
	assign ok = pr inside {7'h16, 7'h14, 7'h15, 7'h1A};
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	a_done_one_cycle: assert property (i_instr_valid && ok |=> o_done && !o_unsupported)
		else $error("done missing");
	a_unsup_refused: assert property (i_instr_valid && !ok |=> o_unsupported && !o_done && $stable(o_wb))
		else $error("bad refusal");
	a_wb_target_idx: assert property (i_instr_valid && ok |=> o_wb.result_target == $past(i_instr.target_field))
		else $error("wrong target");
	a_signed_trap: assert property (i_instr_valid && pr == 7'h14 |=> o_trap_out_of_range == o_flags.v)
		else $error("signed trap wrong");
	a_unsigned_trap: assert property (i_instr_valid && pr == 7'h15 |=> o_trap_out_of_range == !o_flags.c)
		else $error("unsigned trap wrong");
	a_trap_source: assert property (o_trap_out_of_range |-> o_done && $past(pr) inside {7'h14, 7'h15})
		else $error("stray trap");
	a_zero_flag: assert property (o_done |-> o_flags.z == (o_wb.value == 32'h0))
		else $error("zero flag wrong");
	a_neg_flag: assert property (o_done |-> o_flags.n == o_wb.value[31])
		else $error("negative flag wrong");
endmodule
bind sct_alu sct_alu_sva u_sct_alu_sva (.i_clk_sys, .i_rst_n, .i_instr_valid, .i_instr,
	.o_done, .o_unsupported, .o_wb, .o_flags, .o_trap_out_of_range);
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the subtract datapath
`timescale 1ns/10ps
`default_nettype none
module tb_top import sct_pkg::*;;
	logic        clk = 1'b0, rst_n = 1'b0, vld = 1'b0, wr_en = 1'b0, fl_en = 1'b0;
	sct_instr_t  instr = '0;
	logic [7:0]  wr_idx = 8'h00, rd_idx = 8'h00;
	logic [31:0] wr_dat = 32'h0, rd_dat;
	sct_flags_t  fl_wr = '0, flags;
	sct_wb_t     wb;
	logic        done, unsup, trap;
	int          err_total = 0, total_checks = 0, cyc = 0;
	always #10 clk = ~clk;
	sct_alu u_sct_alu (.i_clk_sys(clk), .i_rst_n(rst_n), .i_instr_valid(vld), .i_instr(instr),
		.i_reg_wr_en(wr_en), .i_reg_wr_idx(wr_idx), .i_reg_wr_data(wr_dat),
		.i_reg_rd_idx(rd_idx), .o_reg_rd_data(rd_dat), .i_flags_wr_en(fl_en),
		.i_flags_wr(fl_wr), .o_done(done), .o_unsupported(unsup), .o_wb(wb),
		.o_flags(flags), .o_trap_out_of_range(trap));
	task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] s);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic tick;
		@(posedge clk);
		#1;
	endtask
	// Loads operands and carry, issues one instruction, judges the write-back
	task automatic run(input logic [7:0] op, tg, fa, fb, input logic [31:0] a, b, input logic ci);
		logic [32:0] s;
		logic [31:0] x, y;
		logic        v, tr, rv;
		rv = op[7:1] == 7'h1A;
		y = op[0] ? {24'h0, fb} : b;
		x = rv ? y : a;
		y = rv ? ~a : ~y;
		s = {1'b0, x} + {1'b0, y} + {32'h0, rv | ci};
		v = (x[31] == y[31]) && (s[31] != x[31]);
		tr = (op[7:1] == 7'h14) ? v : (op[7:1] == 7'h15) & !s[32];
		{wr_en, wr_idx, wr_dat} = {1'b1, fa, a};
		tick;
		{wr_en, wr_idx, wr_dat, fl_en, fl_wr} = {!op[0], fb, b, 1'b1, 3'b000, ci};
		tick;
		{wr_en, fl_en, vld, instr} = {3'b001, op, tg, fa, fb};
		tick;
		{vld, rd_idx} = {1'b0, tg};
		chk("done", 40'h1, {39'h0, done});
		chk("wb", {tg, s[31:0]}, wb);
		chk("flags", {36'h0, v, s[31], s[31:0] == 32'h0, s[32]}, {36'h0, flags});
		chk("trap", {39'h0, tr}, {39'h0, trap});
		tick;
		chk("target", {8'h0, s[31:0]}, {8'h0, rd_dat});
		chk("pulses", 40'h0, {38'h0, done, trap});
	endtask
	task automatic s_carry;
		run(8'h2C, 8'h03, 8'h01, 8'h02, 32'h0000_0010, 32'h0000_0011, 1'b1);
		run(8'h2D, 8'h04, 8'h03, 8'hFF, 32'h0000_0100, 32'h0, 1'b0);
	endtask
	task automatic s_signed;
		run(8'h28, 8'h05, 8'h01, 8'h02, 32'h7FFF_FFFF, 32'hFFFF_FFFF, 1'b1);
		run(8'h29, 8'h05, 8'h06, 8'h10, 32'h0000_0020, 32'h0, 1'b1);
	endtask
	task automatic s_unsigned;
		run(8'h2B, 8'h07, 8'h01, 8'h05, 32'h0000_0003, 32'h0, 1'b1);
		run(8'h2A, 8'h08, 8'h01, 8'h02, 32'h0000_0010, 32'h0000_0003, 1'b0);
	endtask
	task automatic s_reverse;
		// Carry cleared: a reverse subtract must ignore it
		run(8'h34, 8'h09, 8'h01, 8'h02, 32'h0000_0005, 32'h0000_0005, 1'b0);
		run(8'h35, 8'h0A, 8'h01, 8'hFF, 32'h0000_0001, 32'h0, 1'b0);
	endtask
	task automatic s_refused;
		sct_wb_t    old;
		sct_flags_t old_fl;
		old = wb;
		old_fl = flags;
		{vld, instr} = {1'b1, 8'h24, 8'h0B, 8'h01, 8'h02};
		tick;
		vld = 1'b0;
		chk("unsup", 40'h2, {38'h0, unsup, done});
		chk("wb kept", old, wb);
		chk("flags kept", {36'h0, old_fl}, {36'h0, flags});
	endtask
	// Mid-run reset clears every registered output at once
	task automatic s_reset;
		rst_n = 1'b0;
		#1;
		chk("reset wb", 40'h0, wb);
		chk("reset state", 40'h0, {33'h0, flags, done, unsup, trap});
		chk("reset read", 40'h0, {8'h0, rd_dat});
		tick;
		rst_n = 1'b1;
	endtask
	// Back-to-back issue: the second word reads the target and carry of the first
	task automatic s_chain;
		{wr_en, wr_idx, wr_dat} = {1'b1, 8'h01, 32'h0};
		tick;
		{wr_idx, wr_dat, fl_en, fl_wr} = {8'h02, 32'h1, 1'b1, 4'h1};
		tick;
		{wr_en, fl_en, vld, instr} = {3'b001, 8'h2C, 8'h03, 8'h01, 8'h02};
		tick;
		instr = {8'h2D, 8'h04, 8'h03, 8'h01};
		chk("chain first", {8'h03, 32'hFFFF_FFFF}, wb);
		chk("chain carry", 40'h4, {36'h0, flags});
		tick;
		vld = 1'b0;
		chk("chain second", {8'h04, 32'hFFFF_FFFD}, wb);
		chk("chain flags", 40'h5, {36'h0, flags});
		chk("chain done", 40'h1, {39'h0, done});
	endtask
	initial begin
		repeat (2) @(posedge clk);
		#1;
		rst_n = 1'b1;
		s_carry();
		s_signed();
		s_unsigned();
		s_reverse();
		s_refused();
		s_reset();
		s_chain();
		tally_and_finish();
	end
	// About forty cycles in all; the ceiling leaves wide margin
	always @(posedge clk) begin
		cyc++;
		if (cyc == 500) begin
			err_total++;
			tally_and_finish();
		end
	end
endmodule
`default_nettype wire
